// ==== rtl/umc_map.vh ====
// register offsets, bit positions and reset values of the modem block
`ifndef UMC_MAP_VH
`define UMC_MAP_VH
`define UMC_NCH 4
`define UMC_AW 5
`define UMC_DW 8
`define UMC_REG_W 3
`define UMC_ADDR_MCR 3'h4
`define UMC_ADDR_MSR 3'h6
`define UMC_MCR_DTR 0
`define UMC_MCR_RTS 1
`define UMC_MSR_CTS 4
`define UMC_MSR_DSR 5
`define UMC_MSR_RI 6
`define UMC_MSR_CD 7
`define UMC_MSR_TERI 2
`define UMC_MCR_RST 8'h00
`define UMC_PIN_IDLE 1'b1
`define UMC_BYTE_ZERO 8'h00
`define UMC_RW_IDLE 1'b1
`endif

// ==== rtl/umc_sync3.v ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module umc_sync3 #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // data
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;
    always @(posedge sys_clk) begin
        if (srst) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            dout <= INIT;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // only take a bit once the two late stages agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // umc_sync3

// ==== rtl/umc_modem.v ====
// modem control and status pins of four uart channels, strobe-mode bus
// Overview of operation
// R1: reset clears all registers, parks outputs and holds tx high, rx ignored.
// R2: with bus mode select low the reset pin is taken as active low.
// R3: a falling edge of the read/write strobe writes the data bus to the chosen register.
// R4: a rising edge of the read/write strobe puts the chosen register on the data bus.
// R5: a low carrier detect input means the modem has found a carrier.
// R6: the clear-to-send input is reported in bit 4 of the modem status register.
// R7: a low data-set-ready means the modem is ready and never affects tx or rx.
// R8: data-terminal-ready goes low when control bit 0 is 1 and high when it is 0.
// R9: a rising ring indicator input raises an interrupt condition.
// R10: request-to-send goes low when control bit 1 is 1 and high when it is 0.
// R11: request-to-send is high after reset and never affects tx or rx.
// R12: the baud clock source is a crystal or an external clock on the oscillator pin; the code only buffers a slow external clock.
// R13: with bus mode select high the reset pin is active high.
// R14: the ring interrupt stays set until the modem status register is read.
`timescale 1ns/100ps
`include "umc_map.vh"
module umc_modem (
    // clock and synchronous system reset
    input wire sys_clk,
    input wire srst,
    // device reset pin and bus mode select (high: host bus ignored)
    input wire reset_pin,
    input wire mode_sel,
    // oscillator pins
    input wire osc_input,
    output reg osc_output,
    // strobe-mode host bus
    input wire cs_n,
    input wire [`UMC_AW-1:0] addr,
    input wire rw_n,
    input wire [`UMC_DW-1:0] data_in,
    output reg [`UMC_DW-1:0] data_out,
    output reg data_oe_n,
    // modem pins, one bit per channel
    input wire [`UMC_NCH-1:0] carrier_detect_n,
    input wire [`UMC_NCH-1:0] cts_n,
    input wire [`UMC_NCH-1:0] dsr_n,
    input wire [`UMC_NCH-1:0] ring_indicator_n,
    output reg [`UMC_NCH-1:0] dtr_n,
    output reg [`UMC_NCH-1:0] rts_n,
    // serial data gating and status
    input wire [`UMC_NCH-1:0] rx_in,
    input wire [`UMC_NCH-1:0] tx_core,
    output reg [`UMC_NCH-1:0] tx_out,
    output reg [`UMC_NCH-1:0] rx_core,
    output reg [`UMC_NCH-1:0] ring_irq,
    output reg dev_in_reset
);

    // bit positions of each pin group in the filtered vector
    localparam P_CS = 0;
    localparam P_OSC = 1;
    localparam P_RW = 2;
    localparam P_RI = 3;
    localparam P_DSR = P_RI + `UMC_NCH;
    localparam P_CTS = P_DSR + `UMC_NCH;
    localparam P_CD = P_CTS + `UMC_NCH;
    localparam P_MODE = P_CD + `UMC_NCH;
    localparam P_RST = P_MODE + 1;
    localparam P_ADDR = P_RST + 1;
    localparam P_DATA = P_ADDR + `UMC_AW;
    localparam P_RX = P_DATA + `UMC_DW;
    localparam SW = P_RX + `UMC_NCH;

    // every pin from outside the clock domain goes through the filter,
    // bus address and data too: they are held long around the strobe
    wire [SW-1:0] raw = {rx_in, data_in, addr, reset_pin, mode_sel,
        carrier_detect_n, cts_n, dsr_n, ring_indicator_n, rw_n,
        osc_input, cs_n};
    wire [SW-1:0] syn;
    umc_sync3 #(.W(SW), .INIT({SW{1'b1}})) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .din(raw),
        .dout(syn)
    );

    wire s_cs_n = syn[P_CS];
    wire s_osc = syn[P_OSC];
    wire s_rw_n = syn[P_RW];
    wire [`UMC_NCH-1:0] s_ri_n = syn[P_RI +: `UMC_NCH];
    wire [`UMC_NCH-1:0] s_dsr_n = syn[P_DSR +: `UMC_NCH];
    wire [`UMC_NCH-1:0] s_cts_n = syn[P_CTS +: `UMC_NCH];
    wire [`UMC_NCH-1:0] s_cd_n = syn[P_CD +: `UMC_NCH];
    wire s_mode = syn[P_MODE];
    wire s_rst_pin = syn[P_RST];
    wire [`UMC_AW-1:0] s_addr = syn[P_ADDR +: `UMC_AW];
    wire [`UMC_DW-1:0] s_data = syn[P_DATA +: `UMC_DW];
    wire [`UMC_NCH-1:0] s_rx = syn[P_RX +: `UMC_NCH];

    // pin polarity follows the bus mode
    wire dev_rst = srst | (s_mode ? s_rst_pin : ~s_rst_pin); // R2 R13

    // address and data lag by the same filter delay as the strobe; one
    // more stage keeps them steady in the cycle that acts on the edge
    reg [`UMC_AW-1:0] addr_q;
    reg [`UMC_DW-1:0] din_q;
    reg rw_prev_q;
    always @(posedge sys_clk) begin
        if (dev_rst) begin
            addr_q <= {`UMC_AW{1'b0}}; // R1
            din_q <= `UMC_BYTE_ZERO;
        end else begin
            addr_q <= s_addr;
            din_q <= s_data;
        end
    end

    wire rw_fall = rw_prev_q & ~s_rw_n;
    wire rw_rise = ~rw_prev_q & s_rw_n;
    wire bus_on = ~s_mode & ~s_cs_n;
    wire [1:0] ch_sel = addr_q[`UMC_AW-1:`UMC_REG_W];
    wire [`UMC_REG_W-1:0] reg_sel = addr_q[`UMC_REG_W-1:0];

    function [`UMC_NCH-1:0] ch_dec;
        input [1:0] c;
        input en;
        begin
            ch_dec = en ? ({{(`UMC_NCH-1){1'b0}}, 1'b1} << c)
                : {`UMC_NCH{1'b0}};
        end
    endfunction

    // status byte of one channel: active high views of low-true pins,
    // unused positions read as zero
    function [`UMC_DW-1:0] msr_img;
        input cd_n;
        input ri_n;
        input dsr_n;
        input cts_n;
        input ring;
        begin
            msr_img = `UMC_BYTE_ZERO;
            msr_img[`UMC_MSR_CD] = ~cd_n; // R5
            msr_img[`UMC_MSR_RI] = ~ri_n;
            msr_img[`UMC_MSR_DSR] = ~dsr_n; // R7
            msr_img[`UMC_MSR_CTS] = ~cts_n; // R6
            msr_img[`UMC_MSR_TERI] = ring; // R14
        end
    endfunction

    wire [`UMC_NCH-1:0] wr_mcr = ch_dec(ch_sel,
        bus_on & rw_fall & (reg_sel == `UMC_ADDR_MCR)); // R3
    wire [`UMC_NCH-1:0] rd_msr = ch_dec(ch_sel,
        bus_on & rw_rise & (reg_sel == `UMC_ADDR_MSR)); // R4

    reg [`UMC_NCH-1:0] ri_prev_q;
    reg [`UMC_NCH-1:0] teri_q;
    reg [`UMC_DW-1:0] mcr_q [0:`UMC_NCH-1];
    wire [`UMC_DW-1:0] msr_w [0:`UMC_NCH-1];

    genvar g;
    generate
        for (g = 0; g < `UMC_NCH; g = g + 1) begin : g_ch
            wire ri_rise = ~ri_prev_q[g] & s_ri_n[g]; // R9
            assign msr_w[g] = msr_img(s_cd_n[g], s_ri_n[g], s_dsr_n[g],
                s_cts_n[g], teri_q[g]); // R5 R6 R7
            always @(posedge sys_clk) begin
                if (dev_rst) begin
                    mcr_q[g] <= `UMC_MCR_RST; // R1
                    teri_q[g] <= 1'b0;
                    ri_prev_q[g] <= `UMC_PIN_IDLE;
                end else begin
                    ri_prev_q[g] <= s_ri_n[g];
                    if (wr_mcr[g]) begin
                        mcr_q[g] <= din_q;
                    end
                    // a new ring edge beats the read-clear
                    if (ri_rise) begin
                        teri_q[g] <= 1'b1; // R9 R14
                    end else if (rd_msr[g]) begin
                        teri_q[g] <= 1'b0; // R14
                    end
                end
            end
            always @(posedge sys_clk) begin
                if (dev_rst) begin
                    dtr_n[g] <= `UMC_PIN_IDLE;
                    rts_n[g] <= `UMC_PIN_IDLE; // R11
                    tx_out[g] <= `UMC_PIN_IDLE; // R1
                    rx_core[g] <= `UMC_PIN_IDLE; // R1
                    ring_irq[g] <= 1'b0;
                end else begin
                    dtr_n[g] <= ~mcr_q[g][`UMC_MCR_DTR]; // R8
                    rts_n[g] <= ~mcr_q[g][`UMC_MCR_RTS]; // R10
                    // modem pins do not gate serial data
                    tx_out[g] <= tx_core[g]; // R7 R11
                    rx_core[g] <= s_rx[g];
                    ring_irq[g] <= teri_q[g];
                end
            end
        end
    endgenerate

    // read data is driven from the strobe rise until the next fall, chip
    // deselect or bus mode select high; bus is released otherwise
    always @(posedge sys_clk) begin
        if (dev_rst) begin
            rw_prev_q <= `UMC_RW_IDLE;
            data_out <= `UMC_BYTE_ZERO;
            data_oe_n <= 1'b1;
            osc_output <= 1'b0;
            dev_in_reset <= 1'b1;
        end else begin
            rw_prev_q <= s_rw_n;
            // buffered clock, sync-delayed; fine for a slow external clock
            osc_output <= s_osc; // R12
            dev_in_reset <= 1'b0;
            if (bus_on & rw_rise) begin
                data_oe_n <= 1'b0; // R4
                if (reg_sel == `UMC_ADDR_MSR) begin
                    data_out <= msr_w[ch_sel];
                end else if (reg_sel == `UMC_ADDR_MCR) begin
                    data_out <= mcr_q[ch_sel];
                end else begin
                    data_out <= `UMC_BYTE_ZERO;
                end
            end else if (rw_fall | s_cs_n | s_mode) begin
                data_oe_n <= 1'b1;
            end
        end
    end
endmodule // umc_modem

// ==== verif/umc_mon_monitor.sv ====
// assertion checker for the modem pin block
`timescale 1ns/100ps
`include "umc_map.vh"
module umc_mon (
    // clock and resets
    input logic sys_clk,
    input logic srst,
    input logic reset_pin,
    input logic mode_sel,
    // host bus
    input logic cs_n,
    input logic [4:0] addr,
    input logic rw_n,
    input logic [7:0] data_in,
    input logic data_oe_n,
    // modem side
    input logic [3:0] dtr_n,
    input logic [3:0] rts_n,
    input logic [3:0] ring_indicator_n,
    input logic [3:0] ring_irq,
    input logic dev_in_reset
);
    default clocking
        @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    wire wr = !cs_n && !mode_sel && addr[2:0] == `UMC_ADDR_MCR;
    AST_RST: assert property (disable iff (1'b0) srst |=>
        &dtr_n && &rts_n && ring_irq == 4'h0 && data_oe_n && dev_in_reset)
        else $error("reset state wrong");
    AST_PIN_LOW: assert property ((!mode_sel && !reset_pin)[*8]
        |=> dev_in_reset) else $error("low pin reset missed");
    AST_PIN_HIGH: assert property ((mode_sel && reset_pin)[*8]
        |=> dev_in_reset) else $error("high pin reset missed");
    AST_RUN: assert property ((mode_sel ^ reset_pin)[*8]
        |=> !dev_in_reset) else $error("reset with pin inactive");
    AST_DTR: assert property ($fell(rw_n) && wr |-> ##6
        dtr_n[addr[4:3]] == !data_in[0]) else $error("dtr wrong");
    AST_RTS: assert property ($fell(rw_n) && wr |-> ##6
        rts_n[addr[4:3]] == !data_in[1]) else $error("rts wrong");
    AST_RD: assert property ($rose(rw_n) && !cs_n && !mode_sel
        |-> ##6 !data_oe_n) else $error("read not driven");
    AST_RING: assert property ($rose(ring_indicator_n[0])
        |-> ##[3:6] ring_irq[0]) else $error("ring flag missed");
    AST_STICKY: assert property ($fell(ring_irq[0])
        |-> !data_oe_n || dev_in_reset) else $error("ring flag lost");
    cover property ($fell(ring_irq[0]));
    cover property ($fell(rw_n) && wr);
    cover property (dev_in_reset && mode_sel);
endmodule // umc_mon
bind umc_modem umc_mon umc_mon_i (.*);

// ==== verif/umc_host.sv ====
// host model on the combined strobe bus
`timescale 1ns/100ps
module umc_host (
    // clock
    input logic sys_clk,
    // strobe bus
    output logic cs_n,
    output logic [4:0] addr,
    output logic rw_n,
    output logic [7:0] data_in
);
    initial begin
        {cs_n, addr, rw_n, data_in} = 15'h7fff;
    end
    // fall writes, rise reads; bus held 8 clocks round each edge
    task automatic cyc(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk) #5;
        {cs_n, addr, data_in} = {1'b0, a, d};
        repeat (8) @(posedge sys_clk);
        #5 rw_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        #5 rw_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        // data no longer held, so never show the old byte
        #5 data_in = ~d;
    endtask
endmodule // umc_host

// ==== verif/tb.sv ====
// self-checking bench for the modem pin block
`timescale 1ns/100ps
module tb;
    logic sys_clk, srst, reset_pin, mode_sel, osc_input, osc_output;
    logic cs_n, rw_n, data_oe_n, dev_in_reset;
    logic osc_seen;
    logic [4:0] addr;
    logic [7:0] data_in, data_out;
    logic [3:0] carrier_detect_n, cts_n, dsr_n, ring_indicator_n;
    logic [3:0] dtr_n, rts_n, rx_in, tx_core, tx_out, rx_core, ring_irq;
    int error_cnt = 0;
    int tests_run = 0;
    // address, write byte, expected read byte
    logic [20:0] rows [7] = '{{5'h04, 8'h01, 8'h01}, {5'h0c, 8'h02, 8'h02},
        {5'h14, 8'h03, 8'h03}, {5'h1c, 8'h00, 8'h00},
        {5'h01, 8'h5a, 8'h00}, {5'h06, 8'hff, 8'ha4}, {5'h0e, 8'h00, 8'h30}};
    umc_modem umc_modem_i (.*);
    umc_host umc_host_i (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always begin
        repeat (2) @(posedge sys_clk);
        #5 osc_input = ~osc_input;
    end
    initial begin
        {srst, reset_pin, mode_sel, osc_input} = 4'hc;
        {carrier_detect_n, cts_n, dsr_n, ring_indicator_n} = 16'hffff;
        {rx_in, tx_core} = 8'h5a;
        tick(20);
        chk({dtr_n, rts_n}, 8'hff);
        chk({tx_out, rx_core}, 8'hff);
        chk({ring_irq, dev_in_reset}, 8'h01);
        srst = 1'b0;
        {carrier_detect_n, cts_n, dsr_n, ring_indicator_n} = 16'hed0e;
        tick(10);
        ring_indicator_n = 4'hf;
        tick(10);
        chk(ring_irq, 4'h1);
        foreach (rows[i]) begin
            umc_host_i.cyc(rows[i][20:16], rows[i][15:8]);
            chk(data_out, rows[i][7:0]);
        end
        chk({dtr_n, rts_n}, 8'ha9);
        chk(ring_irq, 4'h0);
        chk({tx_out, rx_core}, 8'ha5);
        osc_seen = osc_output;
        tick(2);
        chk(osc_output, !osc_seen);
        // strobe mode off: bus writes must be ignored
        {mode_sel, reset_pin} = 2'b10;
        tick(10);
        umc_host_i.cyc(5'h04, 8'h00);
        chk({data_oe_n, dtr_n[0], rts_n[0]}, 8'h05);
        reset_pin = 1'b1;
        tick(10);
        chk({dev_in_reset, dtr_n}, 8'h1f);
        mode_sel = 1'b0;
        tick(10);
        umc_host_i.cyc(5'h04, 8'h03);
        chk({dev_in_reset, dtr_n}, 8'h0e);
        reset_pin = 1'b0;
        tick(10);
        chk({dev_in_reset, dtr_n}, 8'h1f);
        finish_test();
    end
endmodule // tb
